// >>> hdl/eqs_port_sched.sv
`timescale 1ns/1ps
module eqs_port_sched
	import eqs_pkg::*;
#(
	parameter int CW = 8
) (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	// configuration
	input  wire logic                      weighted,
	input  wire logic                      two_q,
	input  wire logic [NQ-1:0][RSV_W-1:0]  weights,
	// queue side
	input  wire logic [NQ-1:0]             q_nonempty,
	input  wire logic                      slot,
	// decision
	output eqs_grant_s                     grant
);

	typedef struct packed {
		logic [NQ-1:0][CW-1:0] credit;
		eqs_grant_s            grant;
	} eqs_sched_s;

	eqs_sched_s state_ff;
	eqs_sched_s nxt_state;

	// ----------------------------------------------------------------
	// highest set bit of a queue mask
	// ----------------------------------------------------------------
	function automatic logic [2:0] eqs_top(input logic [NQ-1:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < NQ; i++) begin
			if (m[i]) begin
				r = {1'b1, i[1:0]};
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// selection per transmit opportunity
	// ----------------------------------------------------------------
	always_comb begin
		logic [NQ-1:0] act;
		logic [NQ-1:0] rdy;
		logic [NQ-1:0] elig;
		logic [2:0]    pick;
		act  = two_q ? MASK_TWO : MASK_FOUR;
		rdy  = q_nonempty & act;
		pick = eqs_top(rdy);
		elig = '0;
		for (int i = 0; i < NQ; i++) begin
			elig[i] = rdy[i] && (state_ff.credit[i] != '0);
		end
		nxt_state = state_ff;
		nxt_state.grant.valid = 1'b0;
		if (!weighted) begin
			// strict priority
			// credits kept full so weighted mode starts a fresh round
			for (int i = 0; i < NQ; i++) begin
				nxt_state.credit[i] = CW'(weights[i]);
			end
		end else if (slot && elig != '0) begin
			pick = eqs_top(elig);
			nxt_state.credit[pick[1:0]] = state_ff.credit[pick[1:0]] - CW'(1);
		end else if (slot && rdy != '0) begin
			// round reload
			// two-queue mode uses the 2:1 weights of the low pair
			for (int i = 0; i < NQ; i++) begin
				nxt_state.credit[i] = CW'(weights[i]);
			end
			nxt_state.credit[pick[1:0]] = CW'(weights[pick[1:0]]) - CW'(1);
		end
		if (slot && pick[2]) begin
			nxt_state.grant.valid = 1'b1;
			nxt_state.grant.queue = pick[1:0];
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign grant = state_ff.grant;

endmodule

// >>> hdl/eqs_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Each port-1 queue and port-2 queue 3 has its own split register: select in bit 7, read-only field in 6..0.
// - All selects clear and global bit 3 clear gives strict highest-queue-first service.
// - With global bit 0 clear, all four selects set gives weighted 8:4:2:1 service from queue 3 down to queue 0.
// - Selects reset to one; read-only fields read 8, 4, 2 and 1 for queues 3 to 0.
// - Flow-control select registers for modes 2, 3, 4 are read-only at 0x10, 0x08, 0x05.
module eqs_top
	import eqs_pkg::*;
(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	// avalon-mm slave
	input  eqs_avm_req_s       avs_req,
	output eqs_avm_rsp_s       avs_rsp,
	// port 1 egress queues
	input  wire logic [NQ-1:0] p1_q_nonempty,
	input  wire logic          p1_tx_slot,
	output eqs_grant_s         p1_grant
);

	typedef struct packed {
		logic [NQ-1:0] p1_sel;
		logic          p2q3_sel;
		logic [7:0]    glob;
		logic [1:0]    last_q;
		eqs_avm_rsp_s  rsp;
	} eqs_top_s;

	eqs_top_s state_ff;
	eqs_top_s nxt_state;

	logic                     weighted;
	logic                     two_q;
	logic [NQ-1:0]            rel;
	logic [NQ-1:0][RSV_W-1:0] weights;
	eqs_grant_s               grant;

	// ----------------------------------------------------------------
	// scheduling mode for port 1
	// ----------------------------------------------------------------
	// fixed weight fields
	assign weights  = {RSV_Q3, RSV_Q2, RSV_Q1, RSV_Q0};
	assign two_q    = state_ff.glob[GLOB_TWO_BIT];
	assign rel      = two_q ? MASK_TWO : MASK_FOUR;
	// strict when any relevant select and the global bit are clear
	// mixed selects with bit 3 clear fall back to strict service
	assign weighted = ((state_ff.p1_sel & rel) == rel) || state_ff.glob[GLOB_WGT_BIT];

	eqs_port_sched #(
		.CW (8)
	) u_p1_sched (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.weighted   (weighted),
		.two_q      (two_q),
		.weights    (weights),
		.q_nonempty (p1_q_nonempty),
		.slot       (p1_tx_slot),
		.grant      (grant)
	);

	// ----------------------------------------------------------------
	// split register read value
	// ----------------------------------------------------------------
	function automatic logic [7:0] eqs_split(input logic sel, input logic [RSV_W-1:0] rsv);
		return {sel, rsv};
	endfunction

	// ----------------------------------------------------------------
	// register file and bus handshake
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] idx;
		logic [7:0] rd;
		logic       wr_go;
		idx   = avs_req.address[ADDR_W-1:2];
		rd    = 8'h00;
		wr_go = 1'b0;
		nxt_state = state_ff;
		if (grant.valid) begin
			nxt_state.last_q = grant.queue;
		end
		case (idx)
			IDX_GLOB:  rd = state_ff.glob;
			IDX_STAT:  rd = {5'h00, weighted, state_ff.last_q};
			IDX_PMFC2: rd = PMFC2_RST;
			IDX_PMFC3: rd = PMFC3_RST;
			IDX_PMFC4: rd = PMFC4_RST;
			IDX_P1Q3:  rd = eqs_split(state_ff.p1_sel[3], RSV_Q3);
			IDX_P1Q2:  rd = eqs_split(state_ff.p1_sel[2], RSV_Q2);
			IDX_P1Q1:  rd = eqs_split(state_ff.p1_sel[1], RSV_Q1);
			IDX_P1Q0:  rd = eqs_split(state_ff.p1_sel[0], RSV_Q0);
			IDX_P2Q3:  rd = eqs_split(state_ff.p2q3_sel, RSV_Q3);
			default:   rd = 8'h00;
		endcase
		// two-cycle access: data loaded and waitrequest dropped together, for one cycle
		if ((avs_req.read || avs_req.write) && state_ff.rsp.waitrequest) begin
			nxt_state.rsp.waitrequest = 1'b0;
			nxt_state.rsp.readdata    = {24'h000000, rd};
		end else begin
			nxt_state.rsp.waitrequest = 1'b1;
			wr_go = avs_req.write && !state_ff.rsp.waitrequest && avs_req.byteenable[0];
		end
		if (wr_go) begin
			case (idx)
				IDX_GLOB: nxt_state.glob        = avs_req.writedata[7:0];
				IDX_P1Q3: nxt_state.p1_sel[3]   = avs_req.writedata[SEL_BIT];
				IDX_P1Q2: nxt_state.p1_sel[2]   = avs_req.writedata[SEL_BIT];
				IDX_P1Q1: nxt_state.p1_sel[1]   = avs_req.writedata[SEL_BIT];
				IDX_P1Q0: nxt_state.p1_sel[0]   = avs_req.writedata[SEL_BIT];
				IDX_P2Q3: nxt_state.p2q3_sel    = avs_req.writedata[SEL_BIT];
				default:  nxt_state.glob        = state_ff.glob;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff.p1_sel          <= {NQ{SEL_RST}};
			state_ff.p2q3_sel        <= SEL_RST;
			state_ff.glob            <= GLOB_RST;
			state_ff.last_q          <= 2'h0;
			state_ff.rsp.readdata    <= '0;
			state_ff.rsp.waitrequest <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign avs_rsp  = state_ff.rsp;
	assign p1_grant = grant;

endmodule

// >>> pkg/eqs_pkg.sv
package eqs_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int NQ     = 4;
	localparam int RSV_W  = 7;

	// ----------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_GLOB  = 8'h05;
	localparam logic [7:0] IDX_STAT  = 8'h06;
	localparam logic [7:0] IDX_PMFC2 = 8'hAC;
	localparam logic [7:0] IDX_PMFC3 = 8'hAD;
	localparam logic [7:0] IDX_PMFC4 = 8'hAE;
	localparam logic [7:0] IDX_P1Q3  = 8'hAF;
	localparam logic [7:0] IDX_P1Q2  = 8'hB0;
	localparam logic [7:0] IDX_P1Q1  = 8'hB1;
	localparam logic [7:0] IDX_P1Q0  = 8'hB2;
	localparam logic [7:0] IDX_P2Q3  = 8'hB3;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]       PMFC2_RST    = 8'h10;
	localparam logic [7:0]       PMFC3_RST    = 8'h08;
	localparam logic [7:0]       PMFC4_RST    = 8'h05;
	localparam int               SEL_BIT      = 7;
	localparam logic             SEL_RST      = 1'b1;
	localparam logic [RSV_W-1:0] RSV_Q3       = 7'h08;
	localparam logic [RSV_W-1:0] RSV_Q2       = 7'h04;
	localparam logic [RSV_W-1:0] RSV_Q1       = 7'h02;
	localparam logic [RSV_W-1:0] RSV_Q0       = 7'h01;
	localparam int               GLOB_WGT_BIT = 3;
	localparam int               GLOB_TWO_BIT = 0;
	localparam logic [7:0]       GLOB_RST     = 8'h00;
	localparam logic [NQ-1:0]    MASK_FOUR    = 4'hF;
	localparam logic [NQ-1:0]    MASK_TWO     = 4'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [3:0]        byteenable;
	} eqs_avm_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic              waitrequest;
	} eqs_avm_rsp_s;

	typedef struct packed {
		logic       valid;
		logic [1:0] queue;
	} eqs_grant_s;

endpackage

// >>> tb/eqs_top_bench.sv
`timescale 1ns/1ps
module eqs_top_bench import eqs_pkg::*;;
	logic          ref_clk = 0, reset_n = 0, p1_tx_slot = 0;
	logic [NQ-1:0] p1_q_nonempty = 4'h0;
	eqs_avm_req_s  avs_req = '0;
	eqs_avm_rsp_s  avs_rsp;
	eqs_grant_s    p1_grant;
	int            error_cnt = 0, compares = 0, cnt [5];
	logic [31:0]   rd;
	logic [3:0]    bus_be = 4'hF;
	logic [7:0]    ri [9] = '{IDX_PMFC2, IDX_PMFC3, IDX_PMFC4, IDX_P1Q3, IDX_P1Q2, IDX_P1Q1,
		IDX_P1Q0, IDX_P2Q3, 8'h00};
	logic [7:0]    rv [9] = '{PMFC2_RST, PMFC3_RST, PMFC4_RST, 8'h88, 8'h84, 8'h82, 8'h81, 8'h88, 8'h00};
	eqs_top eqs_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .avs_req(avs_req), .avs_rsp(avs_rsp),
		.p1_q_nonempty(p1_q_nonempty), .p1_tx_slot(p1_tx_slot), .p1_grant(p1_grant));
	always #25 ref_clk = ~ref_clk;
	// ------------------------------
	// helpers
	// ------------------------------
	task automatic results;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int i;
		@(posedge ref_clk);
		avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {24'h0, wd},
			byteenable: bus_be};
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_rsp.waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			error_cnt++;
			results();
		end
		rd = avs_rsp.readdata;
		avs_req <= '0;
	endtask
	// n slots, tally grants per queue, entry 4 counts refusals
	task automatic run(input int n, input logic [NQ-1:0] ne, input logic [19:0] e);
		cnt = '{default: 0};
		repeat (n) begin
			@(posedge ref_clk);
			p1_q_nonempty <= ne;
			p1_tx_slot <= 1'b1;
			@(posedge ref_clk);
			p1_tx_slot <= 1'b0;
			#1;
			cnt[p1_grant.valid === 1'b1 ? p1_grant.queue : 4]++;
		end
		for (int q = 0; q < 5; q++) chk(cnt[q], e[4*q+:4]);
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_regs;
		for (int k = 0; k < 9; k++) begin
			bus(1'b0, ri[k], 8'h00);
			chk(rd, rv[k]);
		end
		$display("t_regs done");
	endtask
	// select-clear writes, reserved fields written back at reset value
	task automatic t_ro;
		for (int k = 0; k < 9; k++) bus(1'b1, ri[k], rv[k] & 8'h7F);
		for (int k = 0; k < 9; k++) begin
			bus(1'b0, ri[k], 8'h00);
			chk(rd, rv[k] & 8'h7F);
		end
		$display("t_ro done");
	endtask
	task automatic t_strict;
		run(1, 4'h5, 20'h00100);
		chk(p1_grant.queue, 2);
		run(2, 4'hF, 20'h02000);
		run(1, 4'h0, 20'h10000);
		$display("t_strict done");
	endtask
	task automatic t_wrr;
		for (int k = 3; k < 7; k++) bus(1'b1, ri[k], rv[k]);
		run(15, 4'hF, 20'h08421);
		$display("t_wrr done");
	endtask
	task automatic t_two;
		bus(1'b1, IDX_GLOB, 8'h01);
		run(6, 4'hF, 20'h00042);
		run(1, 4'hC, 20'h10000);
		$display("t_two done");
	endtask
	// global force bit: weighted with every select clear, byte lane 0 gates writes
	task automatic t_force;
		for (int k = 3; k < 7; k++) bus(1'b1, ri[k], rv[k] & 8'h7F);
		bus(1'b1, IDX_GLOB, 8'h08);
		run(15, 4'hF, 20'h08421);
		bus(1'b0, IDX_STAT, 8'h00);
		chk(rd, 32'h00000004);
		bus_be = 4'hE;
		bus(1'b1, IDX_GLOB, 8'h00);
		bus_be = 4'hF;
		bus(1'b0, IDX_GLOB, 8'h00);
		chk(rd, 32'h00000008);
		$display("t_force done");
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_regs();
		t_ro();
		t_strict();
		t_wrr();
		t_two();
		t_force();
		results();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		results();
	end
endmodule

// >>> tb/eqs_top_sva.sv
`timescale 1ns/1ps
module eqs_top_sva
	import eqs_pkg::*;
(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	// watched ports
	input  eqs_avm_req_s       avs_req,
	input  eqs_avm_rsp_s       avs_rsp,
	input  wire logic [NQ-1:0] p1_q_nonempty,
	input  wire logic          p1_tx_slot,
	input  eqs_grant_s         p1_grant
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// queue levels seen at the slot edge
	logic [NQ-1:0] ne_ff;
	always_ff @(posedge ref_clk) ne_ff <= p1_q_nonempty;
	wire logic       rd  = avs_req.read && avs_rsp.waitrequest;
	wire logic [7:0] idx = avs_req.address[9:2];
	property p_ack; (avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("access not answered");
	property p_one; !avs_rsp.waitrequest |=> avs_rsp.waitrequest; endproperty
	a_one: assert property (p_one) else $error("wait low too long");
	property p_hi; avs_rsp.readdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_pm2; rd && idx == IDX_PMFC2 |=> avs_rsp.readdata[7:0] == PMFC2_RST; endproperty
	a_pm2: assert property (p_pm2) else $error("mode 2 value wrong");
	property p_pm4; rd && idx == IDX_PMFC4 |=> avs_rsp.readdata[7:0] == PMFC4_RST; endproperty
	a_pm4: assert property (p_pm4) else $error("mode 4 value wrong");
	property p_rsv; rd && idx == IDX_P1Q3 |=> avs_rsp.readdata[6:0] == RSV_Q3; endproperty
	a_rsv: assert property (p_rsv) else $error("split field changed");
	property p_none; p1_tx_slot && p1_q_nonempty == 4'h0 |=> !p1_grant.valid; endproperty
	a_none: assert property (p_none) else $error("grant with empty queues");
	property p_low; p1_tx_slot && p1_q_nonempty[1:0] != 2'h0 |=> p1_grant.valid; endproperty
	a_low: assert property (p_low) else $error("slot wasted");
	property p_src; p1_grant.valid |-> $past(p1_tx_slot) && ne_ff[p1_grant.queue]; endproperty
	a_src: assert property (p_src) else $error("grant to empty queue");
endmodule
bind eqs_top eqs_top_sva eqs_top_sva_i (.ref_clk(ref_clk), .reset_n(reset_n), .avs_req(avs_req),
	.avs_rsp(avs_rsp), .p1_q_nonempty(p1_q_nonempty), .p1_tx_slot(p1_tx_slot), .p1_grant(p1_grant));
